// ==== hw/fpec_pkg.sv ====
// Shared constants, encodings and carriers of the flash program/erase controller.
`default_nettype none
package fpec_pkg;
	// ==========================================================================
	// Register map and field layout
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFF_KEY = 8'h04;
	localparam logic [APB_AW-1:0] OFF_ADDR_LO = 8'h08;
	localparam logic [APB_AW-1:0] OFF_ADDR_HI = 8'h0C;
	localparam int BIT_START = 15;
	localparam int BIT_PERMIT = 14;
	localparam int BIT_ERR = 13;
	localparam int BIT_SIDL = 12;
	localparam int BIT_SWAP = 11;
	localparam int BIT_P2 = 10;
	localparam int OP_LSB = 0;
	localparam int OP_W = 4;
	localparam int BYTE_W = 8;
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [1:0] BOOT_SINGLE = 2'h3;
	// ==========================================================================
	// Array geometry
	localparam int ADDR_W = 24;
	localparam int ROW_WORDS = 64;
	localparam int IDX_W = 6;
	localparam logic [IDX_W-1:0] ROW_LAST = 6'h3F;
	localparam logic [IDX_W-1:0] DWORD_LAST = 6'h01;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h000002;
	localparam logic [ADDR_W-1:0] ROW_MASK = 24'hFFFF80;
	localparam logic [ADDR_W-1:0] DWORD_MASK = 24'hFFFFFC;
	localparam logic [ADDR_W-1:0] PAGE_MASK = 24'hFFFC00;
	localparam logic [ADDR_W-1:0] FIXED_ADDR = 24'h000000;
	localparam int INACT_BIT = 22;
	localparam int CNT_W = 16;
	// ==========================================================================
	// Encodings
	typedef enum logic [3:0] {
		OP_DWORD = 4'h1,
		OP_ROW = 4'h2,
		OP_PAGE = 4'h3,
		OP_INACT = 4'h4,
		OP_CHIP = 4'hE
	} fpec_op_t;
	typedef enum logic [1:0] {
		SQ_IDLE = 2'b00,
		SQ_LOAD = 2'b01,
		SQ_TIME = 2'b10
	} fpec_seq_t;
	typedef enum logic [1:0] {
		KY_NONE = 2'b00,
		KY_FIRST = 2'b01,
		KY_ARMED = 2'b10
	} fpec_key_t;
	// ==========================================================================
	// Carriers and state
	typedef struct packed {
		logic valid;
		logic [IDX_W-1:0] idx;
		logic [ADDR_W-1:0] data;
	} fpec_tbl_t;
	typedef struct packed {
		logic we;
		logic erase;
		logic [OP_W-1:0] op;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] data;
	} fpec_arr_t;
	typedef struct packed {
		logic [1:0] bm_meta;
		logic [1:0] bm;
		fpec_key_t key;
		logic start;
		logic permit;
		logic err;
		logic [OP_W-1:0] op;
		logic sidl;
		logic swap;
		logic p2;
		logic [15:0] addr_lo;
		logic [7:0] addr_hi;
		fpec_seq_t seq;
		logic [IDX_W-1:0] idx;
		logic [IDX_W-1:0] last;
		logic [ADDR_W-1:0] base;
		logic [CNT_W-1:0] cnt;
		logic tgt_inact;
		logic stall;
		logic pdown;
		logic [ROW_WORDS-1:0][ADDR_W-1:0] lat;
		fpec_arr_t arr;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} fpec_state_t;
	localparam fpec_state_t ST_RST = '0;
endpackage
`default_nettype wire

// ==== hw/fpec_top.sv ====
// Flash program/erase controller with unlock key, latches, sequencer and APB registers.
// Contract
// - Start bit 15 launches the chosen operation; hardware clears it at completion.
// - A running operation stalls the processor until it completes.
// - Dual partition: work on the inactive partition never stalls the processor.
// - The key register is write-only and only guards starting operations.
// - Target address held as a 16-bit low word and an 8-bit high byte.
// - Chip and inactive-partition erase use fixed locations, ignoring the address.
// - Permit bit 14 allows operations when 1, inhibits them when 0.
// - Error bit 13 set on improper sequence; reads 0 after normal completion.
// - Idle power-down bit 12 powers the array down in Idle when set.
// - Swap bit 11 reads 1 after a swap in dual mode, 0 otherwise.
// - Software can clear the swap bit; any reset clears it too.
// - Bit 10 shows partition 2 active in dual mode, reads 0 in single mode.
// - Control bits 9 to 4 read as zero.
// - Code 0010 programs a row, 0001 a double word; neither erases.
// - Code 0011 erases a page, 1110 erases the chip.
// - Chip erase spares identification, one-time area and executive memory.
// - Code 0100 erases the inactive partition, only in dual partition modes.
// - Any other operation code is unimplemented.
// - Start, permit, error and code fields reset only on power-on reset.
// - Rows hold 64 instructions; erase blocks span eight rows.
// - Table writes fill holding latches kept until programming runs.
`default_nettype none
module fpec_top
	import fpec_pkg::*;
#(
	parameter logic [CNT_W-1:0] ROW_PROG_CYC = 16'h0100,
	parameter logic [CNT_W-1:0] DWORD_PROG_CYC = 16'h0020,
	parameter logic [CNT_W-1:0] PAGE_ERASE_CYC = 16'h0400,
	parameter logic [CNT_W-1:0] CHIP_ERASE_CYC = 16'h0800
)
(
	// Clock and resets.
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic por_n,
	// APB slave.
	input wire logic [APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor core side.
	input wire fpec_tbl_t tbl_wr,
	input wire logic swap_instr,
	input wire logic idle_entry,
	output logic cpu_stall,
	output logic array_power_down,
	// Boot strap pins.
	input wire logic [1:0] boot_partition_mode,
	// Flash array command.
	output fpec_arr_t arr_cmd
);
	// ==========================================================================
	// Elaboration checks
	if (ROW_PROG_CYC == '0 || DWORD_PROG_CYC == '0 || PAGE_ERASE_CYC == '0 || CHIP_ERASE_CYC == '0)
	begin : g_bad_time
		$error("Operation durations must be at least one cycle.");
	end

	// ==========================================================================
	// Helpers
	function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
		return a == off;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0])
		begin
			r[0 +: BYTE_W] = wd[0 +: BYTE_W];
		end
		if (st[1])
		begin
			r[BYTE_W +: BYTE_W] = wd[BYTE_W +: BYTE_W];
		end
		return r;
	endfunction

	function automatic logic op_valid(input logic [OP_W-1:0] op, input logic dual);
		logic ok;
		ok = 1'b0;
		case (op)
			OP_DWORD, OP_ROW, OP_PAGE, OP_CHIP: ok = 1'b1;
			OP_INACT: ok = dual;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	function automatic logic [CNT_W-1:0] op_time(input logic [OP_W-1:0] op);
		logic [CNT_W-1:0] t;
		t = CHIP_ERASE_CYC;
		case (op)
			OP_DWORD: t = DWORD_PROG_CYC;
			OP_ROW: t = ROW_PROG_CYC;
			OP_PAGE: t = PAGE_ERASE_CYC;
			default: t = CHIP_ERASE_CYC;
		endcase
		return t;
	endfunction

	// ==========================================================================
	// State
	fpec_state_t s_q;
	fpec_state_t s_d;
	logic dual;
	logic busy;
	logic setup;
	logic wr_acc;
	logic [15:0] ctrl_rd;
	logic [15:0] wv;
	logic [ADDR_W-1:0] tgt;

	always_comb
	begin
		s_d = s_q;
		wv = '0;
		// Boot mode is a strap from the pins; two stages before use.
		s_d.bm_meta = boot_partition_mode;
		s_d.bm = s_q.bm_meta;
		dual = s_q.bm != BOOT_SINGLE;
		busy = s_q.seq != SQ_IDLE;
		tgt = {s_q.addr_hi, s_q.addr_lo};
		ctrl_rd = '0;
		ctrl_rd[BIT_START] = s_q.start;
		ctrl_rd[BIT_PERMIT] = s_q.permit;
		ctrl_rd[BIT_ERR] = s_q.err;
		ctrl_rd[BIT_SIDL] = s_q.sidl;
		ctrl_rd[BIT_SWAP] = s_q.swap & dual;
		ctrl_rd[BIT_P2] = s_q.p2 & dual;
		ctrl_rd[OP_LSB +: OP_W] = s_q.op;
		s_d.arr.we = 1'b0;
		s_d.arr.erase = 1'b0;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		setup = psel && !penable;
		wr_acc = psel && penable && s_q.pready && pwrite;
		// Zero-wait slave: the answer is ready in the first access cycle.
		if (setup)
		begin
			s_d.pready = 1'b1;
			s_d.prdata = '0;
			if (reg_hit(paddr, OFF_CTRL))
			begin
				s_d.prdata[15:0] = ctrl_rd;
			end
			else if (reg_hit(paddr, OFF_KEY))
			begin
				s_d.prdata = '0;
			end
			else if (reg_hit(paddr, OFF_ADDR_LO))
			begin
				s_d.prdata[15:0] = s_q.addr_lo;
			end
			else if (reg_hit(paddr, OFF_ADDR_HI))
			begin
				s_d.prdata[7:0] = s_q.addr_hi;
			end
			else
			begin
				s_d.pslverr = 1'b1;
			end
		end
		// ======================================================================
		// Sequencer: latches stream out one word per cycle, then the self-timed wait.
		case (s_q.seq)
			SQ_LOAD:
			begin
				s_d.arr.we = 1'b1;
				s_d.arr.addr = s_q.base + ADDR_W'(s_q.idx) * ADDR_STEP;
				s_d.arr.data = s_q.lat[s_q.idx];
				s_d.idx = s_q.idx + 1'b1;
				if (s_q.idx == s_q.last)
				begin
					s_d.seq = SQ_TIME;
				end
			end
			SQ_TIME:
			begin
				s_d.cnt = s_q.cnt - 1'b1;
				if (s_q.cnt == CNT_W'(1))
				begin
					s_d.seq = SQ_IDLE;
					s_d.start = 1'b0;
				end
			end
			default:
			begin
				s_d.seq = SQ_IDLE;
			end
		endcase
		// ======================================================================
		// Register writes.
		if (wr_acc)
		begin
			if (reg_hit(paddr, OFF_KEY))
			begin
				// Only an unbroken 55h, AAh pair arms a start.
				if (pstrb[0] && pwdata[7:0] == KEY_FIRST)
				begin
					s_d.key = KY_FIRST;
				end
				else if (pstrb[0] && pwdata[7:0] == KEY_SECOND && s_q.key == KY_FIRST)
				begin
					s_d.key = KY_ARMED;
				end
				else
				begin
					s_d.key = KY_NONE;
				end
			end
			else
			begin
				s_d.key = KY_NONE;
				if (reg_hit(paddr, OFF_CTRL))
				begin
					wv = merge16(ctrl_rd, pwdata, pstrb);
					s_d.sidl = wv[BIT_SIDL];
					if (!wv[BIT_SWAP])
					begin
						s_d.swap = 1'b0;
					end
					if (!busy)
					begin
						s_d.op = wv[OP_LSB +: OP_W];
						s_d.permit = wv[BIT_PERMIT];
						if (wv[BIT_START] && pstrb[1])
						begin
							if (s_q.key == KY_ARMED && wv[BIT_PERMIT] && op_valid(wv[OP_LSB +: OP_W], dual))
							begin
								s_d.start = 1'b1;
								s_d.err = 1'b0;
								s_d.cnt = op_time(wv[OP_LSB +: OP_W]);
								s_d.idx = '0;
								s_d.arr.op = wv[OP_LSB +: OP_W];
								s_d.tgt_inact = dual && (wv[OP_LSB +: OP_W] == OP_INACT || tgt[INACT_BIT]);
								if (wv[OP_LSB +: OP_W] == OP_ROW)
								begin
									s_d.seq = SQ_LOAD;
									s_d.base = tgt & ROW_MASK;
									s_d.last = ROW_LAST;
								end
								else if (wv[OP_LSB +: OP_W] == OP_DWORD)
								begin
									s_d.seq = SQ_LOAD;
									s_d.base = tgt & DWORD_MASK;
									s_d.last = DWORD_LAST;
								end
								else
								begin
									s_d.seq = SQ_TIME;
									s_d.arr.erase = 1'b1;
									// The array spares its protected areas on a chip erase.
									s_d.arr.addr = (wv[OP_LSB +: OP_W] == OP_PAGE) ? (tgt & PAGE_MASK) : FIXED_ADDR;
								end
							end
							else
							begin
								s_d.err = 1'b1;
							end
						end
					end
				end
				else if (reg_hit(paddr, OFF_ADDR_LO))
				begin
					s_d.addr_lo = merge16(s_q.addr_lo, pwdata, pstrb);
				end
				else if (reg_hit(paddr, OFF_ADDR_HI) && pstrb[0])
				begin
					s_d.addr_hi = pwdata[7:0];
				end
			end
		end
		// ======================================================================
		// Core side: latches, swap and power.
		if (tbl_wr.valid)
		begin
			s_d.lat[tbl_wr.idx] = tbl_wr.data;
		end
		// A swap in the same cycle as a software clear wins.
		if (swap_instr && dual)
		begin
			s_d.swap = 1'b1;
			s_d.p2 = !s_q.p2;
		end
		s_d.pdown = idle_entry && s_q.sidl;
		s_d.stall = (s_d.seq != SQ_IDLE) && !s_d.tgt_inact;
		// The system reset leaves power-on-only fields and a running operation alone.
		if (!nrst)
		begin
			s_d.key = KY_NONE;
			s_d.sidl = 1'b0;
			s_d.swap = 1'b0;
			s_d.pdown = 1'b0;
			s_d.prdata = '0;
			s_d.pready = 1'b0;
			s_d.pslverr = 1'b0;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!por_n)
		begin
			s_q <= ST_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign cpu_stall = s_q.stall;
	assign array_power_down = s_q.pdown;
	assign arr_cmd = s_q.arr;

	// ==========================================================================
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst || !por_n);

	sequence load_end_s;
		s_q.seq == SQ_LOAD ##1 s_q.seq == SQ_TIME;
	endsequence

	sequence start_req_s;
		psel && penable && pready && pwrite && paddr == OFF_CTRL && pwdata[BIT_START] && pstrb[1];
	endsequence

	start_clear_a: assert property (s_q.seq == SQ_TIME && s_q.cnt == CNT_W'(1) |=> !s_q.start && !busy)
		else $error("Start bit not cleared at completion.");
	stall_hold_a: assert property (busy && !s_q.tgt_inact |-> cpu_stall)
		else $error("Processor not stalled during operation.");
	inact_run_a: assert property (s_q.tgt_inact && busy |-> !cpu_stall)
		else $error("Processor stalled for inactive partition work.");
	key_gate_a: assert property ($rose(s_q.start) |-> $past(s_q.key) == KY_ARMED && s_q.permit)
		else $error("Operation started without key pair or permit.");
	bad_start_a: assert property (start_req_s ##0 (s_q.key != KY_ARMED && !busy) |=> s_q.err && !s_q.start)
		else $error("Improper start did not flag an error.");
	op_lock_a: assert property (busy && psel && penable && pready && pwrite |=> $stable(s_q.op) && $stable(s_q.permit))
		else $error("Operation code changed while busy.");
	fixed_addr_a: assert property (arr_cmd.erase && arr_cmd.op != OP_PAGE |-> arr_cmd.addr == FIXED_ADDR)
		else $error("Fixed erase used the address registers.");
	row_len_a: assert property (load_end_s |-> s_q.arr.op != OP_ROW || $past(s_q.idx) == ROW_LAST)
		else $error("Row program did not stream a full row.");
	single_read_a: assert property (setup && paddr == OFF_CTRL && s_q.bm == BOOT_SINGLE |=>
		!prdata[BIT_SWAP] && !prdata[BIT_P2] && prdata[BIT_P2-1:OP_W] == '0)
		else $error("Single mode status bits not zero.");
	no_inact_a: assert property ($rose(s_q.start) && s_q.bm == BOOT_SINGLE |-> s_q.arr.op != OP_INACT)
		else $error("Inactive erase started in single mode.");
endmodule
`default_nettype wire

// ==== verification/fpec_flash_model.sv ====
// Flash array model that tallies the program and erase commands of the controller.
`default_nettype none
module fpec_flash_model
	import fpec_pkg::*;
(
	// Clock and tally clear.
	input wire logic sys_clk,
	input wire logic clr,
	// Array command.
	input wire fpec_arr_t arr_cmd,
	// Tallies.
	output logic [7:0] we_cnt,
	output logic [7:0] er_cnt,
	output logic [ADDR_W-1:0] first_addr,
	output logic [ADDR_W-1:0] data_sum,
	output logic [7:0] bad_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================================
	// Tally logic
	// A step check catches a skipped or repeated row word that a plain count would miss.
	always @(posedge sys_clk)
	begin
		if (clr)
		begin
			we_cnt <= 8'h00;
			er_cnt <= 8'h00;
			data_sum <= '0;
			bad_cnt <= 8'h00;
		end
		else if (arr_cmd.we)
		begin
			we_cnt <= we_cnt + 8'h01;
			data_sum <= data_sum ^ arr_cmd.data;
			if (we_cnt == 8'h00)
				first_addr <= arr_cmd.addr;
			else if (arr_cmd.addr !== first_addr + ADDR_W'({we_cnt, 1'b0}))
				bad_cnt <= bad_cnt + 8'h01;
			if (arr_cmd.erase || arr_cmd.op > 4'h2)
				bad_cnt <= bad_cnt + 8'h01;
		end
		else if (arr_cmd.erase)
		begin
			er_cnt <= er_cnt + 8'h01;
			first_addr <= arr_cmd.addr;
			if (arr_cmd.op < 4'h3)
				bad_cnt <= bad_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ==== verification/flash_program_erase_control_tb.sv ====
// Self-checking testbench of the flash program/erase controller.
`default_nettype none
module flash_program_erase_control_tb
	import fpec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	fpec_tbl_t tbl_wr = '0;
	logic swap_instr = 1'b0;
	logic idle_entry = 1'b0;
	logic cpu_stall;
	logic array_power_down;
	logic [1:0] boot_partition_mode = 2'b11;
	fpec_arr_t arr_cmd;
	logic clr = 1'b1;
	logic [7:0] we_cnt;
	logic [7:0] er_cnt;
	logic [7:0] bad_cnt;
	logic [ADDR_W-1:0] first_addr;
	logic [ADDR_W-1:0] data_sum;
	logic [ADDR_W-1:0] lsum;
	logic [ADDR_W-1:0] a;
	logic [31:0] lf = 32'hEC4E;
	logic [31:0] rd;
	logic slv;
	logic dual;
	int num_errors = 0;
	int tests_run = 0;
	logic [3:0] ops [6] = '{OP_ROW, OP_DWORD, OP_PAGE, OP_CHIP, OP_PAGE, OP_INACT};
	logic [16:0] bad_tab [4] = '{{1'b0, 16'hC002}, {1'b1, 16'h8002}, {1'b1, 16'hC005}, {1'b1, 16'hC004}};
	// ==========================================================================
	// Design and array model
	fpec_top #(.ROW_PROG_CYC(16'h0004), .DWORD_PROG_CYC(16'h0002), .PAGE_ERASE_CYC(16'h0004),
		.CHIP_ERASE_CYC(16'h0004)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tbl_wr(tbl_wr), .swap_instr(swap_instr), .idle_entry(idle_entry),
		.cpu_stall(cpu_stall), .array_power_down(array_power_down),
		.boot_partition_mode(boot_partition_mode), .arr_cmd(arr_cmd));
	fpec_flash_model u_flash (.sys_clk(sys_clk), .clr(clr), .arr_cmd(arr_cmd), .we_cnt(we_cnt),
		.er_cnt(er_cnt), .first_addr(first_addr), .data_sum(data_sum), .bad_cnt(bad_cnt));
	// ==========================================================================
	// Helpers
	initial
		forever #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [ADDR_W-1:0] exp_addr(input logic [3:0] op, input logic [ADDR_W-1:0] v);
		case (op)
			OP_ROW: return v & ROW_MASK;
			OP_DWORD: return v & DWORD_MASK;
			OP_PAGE: return v & PAGE_MASK;
			default: return FIXED_ADDR;
		endcase
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Address writes go first because any write between the key and the start disarms it.
	task automatic start(input logic [15:0] v, input logic [ADDR_W-1:0] ad, input logic key);
		clr <= 1'b1;
		apb(1'b1, OFF_ADDR_LO, {16'h0000, ad[15:0]});
		clr <= 1'b0;
		apb(1'b1, OFF_ADDR_HI, {24'h000000, ad[23:16]});
		if (key)
		begin
			apb(1'b1, OFF_KEY, {24'h000000, KEY_FIRST});
			apb(1'b1, OFF_KEY, {24'h000000, KEY_SECOND});
		end
		apb(1'b1, OFF_CTRL, {16'h0000, v});
	endtask
	task automatic wait_done;
		apb(1'b0, OFF_CTRL, 32'h0);
		while (rd[BIT_START] !== 1'b0)
			apb(1'b0, OFF_CTRL, 32'h0);
	endtask
	task automatic swap_pulse;
		@(posedge sys_clk);
		swap_instr <= 1'b1;
		@(posedge sys_clk);
		swap_instr <= 1'b0;
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		results;
	end
	// ==========================================================================
	// Scenarios
	initial
	begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		por_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd);
		apb(1'b0, OFF_KEY, 32'h0);
		chk("key read", 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped slverr", 32'h1, slv);
		lsum = '0;
		for (int i = 0; i < ROW_WORDS; i++)
		begin
			lf = lfsr(lf);
			@(posedge sys_clk);
			tbl_wr <= '{1'b1, IDX_W'(i), lf[23:0]};
			lsum = lsum ^ lf[23:0];
		end
		@(posedge sys_clk);
		tbl_wr <= '0;
		foreach (bad_tab[k])
		begin
			start(bad_tab[k][15:0], 24'h000100, bad_tab[k][16]);
			apb(1'b0, OFF_CTRL, 32'h0);
			chk("refused start", 32'h0, rd[BIT_START]);
			chk("error flag", 32'h1, rd[BIT_ERR]);
			chk("refused command", 32'h0, we_cnt | er_cnt);
		end
		$display("refused starts done");
		foreach (ops[k])
		begin
			dual = (k >= 4);
			if (k == 4)
			begin
				boot_partition_mode <= 2'b10;
				repeat (3) @(posedge sys_clk);
			end
			lf = lfsr(lf);
			a = lf[23:0] | (dual ? 24'h400000 : 24'h000000);
			start(16'hC000 | 16'(ops[k]), a, 1'b1);
			if (ops[k] == OP_ROW)
				apb(1'b1, OFF_CTRL, 32'h4001);
			@(posedge sys_clk);
			chk("stall busy", !dual, cpu_stall);
			wait_done;
			chk("ctrl done", 32'h4000 | 32'(ops[k]), rd);
			chk("stall done", 32'h0, cpu_stall);
			chk("we pulses", (ops[k] == OP_ROW) ? 8'h40 : (ops[k] == OP_DWORD) ? 8'h02 : 8'h00, we_cnt);
			chk("erase pulses", ops[k] > 4'h2, er_cnt);
			chk("first addr", exp_addr(ops[k], a), first_addr);
			chk("addr steps", 32'h0, bad_cnt);
			if (ops[k] == OP_ROW)
				chk("latch data", lsum, data_sum);
			apb(1'b0, OFF_ADDR_LO, 32'h0);
			chk("addr low", {16'h0000, a[15:0]}, rd);
			apb(1'b0, OFF_ADDR_HI, 32'h0);
			chk("addr high", {24'h000000, a[23:16]}, rd);
			$display("operation %h done", ops[k]);
		end
		apb(1'b1, OFF_CTRL, 32'h4003);
		swap_pulse;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("swap set", 32'h4C03, rd);
		apb(1'b1, OFF_CTRL, 32'h4003);
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("swap cleared", 32'h4403, rd);
		start(16'hC003, 24'h000000, 1'b0);
		swap_pulse;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("second swap", 32'h6803, rd);
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("after nrst", 32'h6003, rd);
		$display("swap and reset done");
		apb(1'b1, OFF_CTRL, 32'h1000);
		idle_entry <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk("power down", 32'h1, array_power_down);
		apb(1'b1, OFF_CTRL, 32'h0);
		repeat (3) @(posedge sys_clk);
		chk("power kept", 32'h0, array_power_down);
		idle_entry <= 1'b0;
		$display("idle power done");
		results;
	end
endmodule
`default_nettype wire
